// File: src/phy_specific_control.sv
`include "phy_ctrl_consts.svh"
`default_nettype none
module phy_specific_control
  import phy_ctrl_pkg::*;
#(
  parameter int NUM_EVENTS = 6,
  parameter int FIFO_SLOTS = 8
) (
  input  wire logic                  mclk_in,
  input  wire logic                  reset_in,
  input  wire logic [9:0]            address_in,
  input  wire logic                  read_in,
  input  wire logic                  write_in,
  input  wire logic [3:0]            byteenable_in,
  input  wire logic [31:0]           writedata_in,
  output logic      [31:0]           readdata_out,
  output logic                       waitrequest_out,
  output logic                       irq_out,
  input  wire logic [NUM_EVENTS-1:0] event_pulse_in,
  input  wire logic                  loopback_en_in,
  input  wire logic                  rx_nibble_valid_in,
  input  wire logic [3:0]            rx_nibble_in,
  input  wire logic                  tx_nibble_ready_in,
  output logic                       tx_nibble_valid_out,
  output logic      [3:0]            tx_nibble_out,
  input  wire logic                  raw_collision_in,
  input  wire logic                  full_duplex_in,
  output logic                       collision_out,
  output logic                       scrambler_bypass_out,
  input  wire logic                  shared_irq_powerdown_pin_in,
  output logic                       shared_irq_powerdown_pin_out,
  output logic                       shared_irq_powerdown_pin_oe_out,
  output logic                       powerdown_req_out
);

  // All state of the block in one record.
  typedef struct packed {
    ctrl_t                             ctrl;
    logic [NUM_EVENTS-1:0]             ev_stat;
    logic [NUM_EVENTS-1:0]             ev_en;
    logic [1:0]                        irq_stat;
    logic [1:0]                        irq_mask;
    logic                              ack;
    logic [31:0]                       rdata;
    logic                              pin_s1;
    logic                              pin_s2;
    logic [FIFO_SLOTS-1:0][3:0]        mem;
    logic [$clog2(FIFO_SLOTS)-1:0]     wptr;
    logic [$clog2(FIFO_SLOTS)-1:0]     rptr;
    logic [$clog2(FIFO_SLOTS):0]       count;
    logic [3:0]                        tx_nib;
    logic                              tx_vld;
  } state_t;

  localparam int PW = $clog2(FIFO_SLOTS);
  localparam int CW = PW + 1;

  state_t   s_q;
  state_t   s_d;
  avs_req_t req;
  logic     irq_req;
  logic     fifo_wr;
  logic     fifo_rd;
  logic     fifo_err;
  logic [CW-1:0] depth_lim;

  function automatic logic [3:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0:    depth_of = `DEPTH_CODE0;
      2'h1:    depth_of = `DEPTH_CODE1;
      2'h2:    depth_of = `DEPTH_CODE2;
      default: depth_of = `DEPTH_CODE3;
    endcase
  endfunction

  // Byte lane merge for writes; only lanes 0 and 1 hold data here.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // Control register image; reserved bits are constant zero.
  function automatic logic [15:0] ctrl_image(input ctrl_t c);
    logic [15:0] v;
    v = 16'h0000;
    v[`B_SCR_BYPASS] = c.scr_bypass;
    v[`B_DEPTH_HI:`B_DEPTH_LO] = c.depth;
    v[`B_FD_COL] = c.fd_col;
    v[`B_POL] = c.pol;
    v[`B_TEST] = c.test;
    v[`B_INT_EN] = c.int_en;
    v[`B_INT_OE] = c.int_oe;
    return v;
  endfunction

  assign req = '{address_in, read_in, write_in, byteenable_in, writedata_in};

  // One wait cycle per access: the answer comes in the cycle in which ack is set.
  assign waitrequest_out = (req.read | req.write) & ~s_q.ack;
  assign readdata_out = s_q.rdata;

  // request before polarity
  // The test bit bypasses the global gate so software can prove the wiring.
  assign irq_req = s_q.ctrl.test |
                   (s_q.ctrl.int_en & |(s_q.ev_stat & s_q.ev_en));

  assign depth_lim = CW'(depth_of(s_q.ctrl.depth));
  assign fifo_wr = loopback_en_in & rx_nibble_valid_in;
  assign fifo_rd = loopback_en_in & tx_nibble_ready_in;
  assign fifo_err = (fifo_wr & ~fifo_rd & (s_q.count >= depth_lim)) |
                    (fifo_rd & (s_q.count == '0));

  // Next state of everything.
  always_comb begin
    logic [15:0] wv;
    logic [7:0]  idx;
    logic        acc;
    logic        do_wr;
    logic        do_rd;
    logic [1:0]  irq_set;
    wv = 16'h0000;
    s_d = s_q;
    idx = req.address[9:2];
    acc = (req.read | req.write) & s_q.ack;
    do_wr = acc & req.write;
    do_rd = acc & req.read;
    irq_set = 2'h0;
    s_d.pin_s1 = shared_irq_powerdown_pin_in;
    s_d.pin_s2 = s_q.pin_s1;
    // Acknowledge toggles so back to back requests each see one wait.
    s_d.ack = (req.read | req.write) & ~s_q.ack;
    // Read data is captured while waiting, stable when it is taken.
    if ((req.read | req.write) & ~s_q.ack) begin
      case (idx)
        `IDX_CTRL:     s_d.rdata = {16'h0000, ctrl_image(s_q.ctrl)};
        `IDX_EVENT: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rdata[`B_EV_STAT_LO +: NUM_EVENTS] = s_q.ev_stat;
          s_d.rdata[`B_EV_EN_LO +: NUM_EVENTS] = s_q.ev_en;
        end
        `IDX_IRQ_STAT: s_d.rdata = {30'h0000_0000, s_q.irq_stat};
        `IDX_IRQ_MASK: s_d.rdata = {30'h0000_0000, s_q.irq_mask};
        default:       s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (do_wr && idx == `IDX_CTRL) begin
      wv = merge16(ctrl_image(s_q.ctrl), req.writedata, req.byteenable);
      s_d.ctrl.scr_bypass = wv[`B_SCR_BYPASS];
      s_d.ctrl.depth = wv[`B_DEPTH_HI:`B_DEPTH_LO];
      s_d.ctrl.fd_col = wv[`B_FD_COL];
      s_d.ctrl.pol = wv[`B_POL];
      s_d.ctrl.test = wv[`B_TEST];
      s_d.ctrl.int_en = wv[`B_INT_EN];
      s_d.ctrl.int_oe = wv[`B_INT_OE];
    end
    if (do_wr && idx == `IDX_EVENT && req.byteenable[0])
      s_d.ev_en = req.writedata[`B_EV_EN_LO +: NUM_EVENTS];
    if (do_wr && idx == `IDX_IRQ_MASK && req.byteenable[0])
      s_d.irq_mask = req.writedata[1:0];
    if (do_rd && idx == `IDX_EVENT)
      s_d.ev_stat = '0;
    s_d.ev_stat = s_d.ev_stat | event_pulse_in;
    // Own sticky bits: one-to-clear, a new event in that cycle wins.
    irq_set[`IRQ_B_EVENT] = |event_pulse_in;
    irq_set[`IRQ_B_FIFO] = fifo_err;
    if (do_wr && idx == `IDX_IRQ_STAT && req.byteenable[0])
      s_d.irq_stat = s_q.irq_stat & ~req.writedata[1:0];
    s_d.irq_stat = s_d.irq_stat | irq_set;
    s_d.tx_vld = 1'b0;
    if (!loopback_en_in) begin
      s_d.count = '0;
      s_d.wptr = '0;
      s_d.rptr = '0;
    end else begin
      if (fifo_rd && s_q.count != '0) begin
        s_d.tx_nib = s_q.mem[s_q.rptr];
        s_d.tx_vld = 1'b1;
        s_d.rptr = PW'(s_q.rptr + 1'b1);
      end
      if (fifo_wr && (s_q.count < depth_lim || (fifo_rd && s_q.count != '0)))
      begin
        s_d.mem[s_q.wptr] = rx_nibble_in;
        s_d.wptr = PW'(s_q.wptr + 1'b1);
      end
      s_d.count = CW'(s_q.count
        + CW'(s_d.wptr != s_q.wptr) - CW'(s_d.rptr != s_q.rptr));
    end
  end

  // State register.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.ctrl.depth <= `CTRL_DEPTH_RST;
      s_q.ctrl.pol <= `CTRL_POL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign scrambler_bypass_out = s_q.ctrl.scr_bypass;

  assign collision_out = raw_collision_in &
                         (~full_duplex_in | s_q.ctrl.fd_col);

  // pin role; polarity on the driven level.
  assign shared_irq_powerdown_pin_oe_out = s_q.ctrl.int_oe;
  assign shared_irq_powerdown_pin_out = irq_req ^ s_q.ctrl.pol;
  // Pin low means power down while the pin is an input.
  assign powerdown_req_out = ~s_q.ctrl.int_oe & ~s_q.pin_s2;

  // Level interrupt toward software from its own sticky bits.
  assign irq_out = |(s_q.irq_stat & s_q.irq_mask);

  assign tx_nibble_valid_out = s_q.tx_vld;
  assign tx_nibble_out = s_q.tx_nib;

  // Checks kept next to the logic.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  sequence s_ctrl_write;
    write_in && !waitrequest_out && address_in[9:2] == `IDX_CTRL
      && byteenable_in[1];
  endsequence

  a_reserved_read_zero: assert property (
    read_in && !waitrequest_out && address_in[9:2] == `IDX_CTRL
    |-> readdata_out[`B_RSV_SINGLE] == 1'b0
    && readdata_out[`B_RSV_HI:`B_RSV_LO] == 3'h0)
    else $error("reserved control bits not zero");

  a_depth_write_lands: assert property (
    s_ctrl_write |=> s_q.ctrl.depth == $past(writedata_in[9:8]))
    else $error("depth field did not take written value");

  a_scram_follows_bit: assert property (
    s_ctrl_write |=> scrambler_bypass_out == $past(writedata_in[11]))
    else $error("scrambler bypass not following bit");

  a_fifo_depth_bound: assert property (
    s_q.count <= depth_lim || $past(s_q.ctrl.depth) != s_q.ctrl.depth)
    else $error("loopback fifo above selected depth");

  a_fifo_order_out: assert property (
    loopback_en_in && tx_nibble_ready_in && s_q.count != '0
    |=> tx_nibble_valid_out && tx_nibble_out == $past(s_q.mem[s_q.rptr]))
    else $error("loopback nibble not delivered");

  a_col_full_duplex: assert property (
    full_duplex_in && !s_q.ctrl.fd_col |-> !collision_out)
    else $error("collision in full duplex while not allowed");

  a_col_allowed_fd: assert property (
    raw_collision_in && s_q.ctrl.fd_col |-> collision_out)
    else $error("allowed collision not signalled");

  a_pol_active_low: assert property (
    s_q.ctrl.pol && s_q.ctrl.test |-> !shared_irq_powerdown_pin_out)
    else $error("active low interrupt not driven low");

  a_pol_active_high: assert property (
    !s_q.ctrl.pol && !irq_req |-> !shared_irq_powerdown_pin_out)
    else $error("active high interrupt not idle low");

  a_test_holds_irq: assert property (
    s_q.ctrl.test [*3] |-> irq_req)
    else $error("test interrupt dropped while set");

  a_gate_disabled: assert property (
    !s_q.ctrl.int_en && !s_q.ctrl.test |-> !irq_req)
    else $error("event interrupt with global gate off");

  a_pin_role: assert property (
    shared_irq_powerdown_pin_oe_out == s_q.ctrl.int_oe
    && !(s_q.ctrl.int_oe && powerdown_req_out))
    else $error("pin role not following output enable");

  a_event_sets_flag: assert property (
    event_pulse_in[0] |=> s_q.ev_stat[0])
    else $error("event flag lost");

  a_read_clears_flag: assert property (
    read_in && !waitrequest_out && address_in[9:2] == `IDX_EVENT
    && event_pulse_in == '0 |=> s_q.ev_stat == '0)
    else $error("event flags not cleared by read");

  a_event_reaches_req: assert property (
    s_q.ctrl.int_en && |(s_q.ev_stat & s_q.ev_en) |-> irq_req)
    else $error("enabled pending event gave no request");

  // Own sticky bits: an overflow or underflow must be remembered.
  a_fifo_err_sticky: assert property (
    fifo_err |=> s_q.irq_stat[`IRQ_B_FIFO])
    else $error("fifo error not recorded");

  a_flush_empty: assert property (
    !loopback_en_in |=> s_q.count == '0)
    else $error("loopback fifo not flushed");

  a_pop_empty_none: assert property (
    loopback_en_in && tx_nibble_ready_in && s_q.count == '0
    |=> !tx_nibble_valid_out)
    else $error("nibble delivered from empty fifo");

  // The idle level must follow the polarity bit in both settings.
  a_pin_idle_level: assert property (
    !irq_req |-> shared_irq_powerdown_pin_out == s_q.ctrl.pol)
    else $error("pin not at idle level");

  a_pin_drive_high: assert property (
    !s_q.ctrl.pol && irq_req |-> shared_irq_powerdown_pin_out)
    else $error("active high interrupt not driven high");

  a_mask_write_lands: assert property (
    write_in && !waitrequest_out && address_in[9:2] == `IDX_IRQ_MASK
    && byteenable_in[0] |=> s_q.irq_mask == $past(writedata_in[1:0]))
    else $error("interrupt mask did not take written value");

  // Enables feed the gate, so a lost write silences an event for good.
  a_enable_write_lands: assert property (
    write_in && !waitrequest_out && address_in[9:2] == `IDX_EVENT
    && byteenable_in[0]
    |=> s_q.ev_en == $past(writedata_in[`B_EV_EN_LO +: NUM_EVENTS]))
    else $error("event enables did not take written value");

  // Back to back requests must each see exactly one wait cycle.
  a_wait_one_cycle: assert property (
    (read_in || write_in) && waitrequest_out
    && $stable(address_in) |=> !waitrequest_out)
    else $error("answer not given after one wait cycle");

endmodule
`default_nettype wire

// File: include/phy_ctrl_consts.svh
`ifndef PHY_CTRL_CONSTS_SVH
`define PHY_CTRL_CONSTS_SVH
// What this block does
// - Bit 11 bypasses the transmit scrambler.
// - Bits 10 and 7:5 ignore writes, read zero.
// - Bits 9:8 select loopback depth, reset 01.
// - Far-end loopback nibbles pass the elastic FIFO.
// - Bit 4 allows collision in full duplex.
// - Otherwise collision appears in half duplex only.
// - Polarity one: idle high, pending drives low.
// - Polarity zero: idle low, pending drives high.
// - Test bit forces interrupt while it stays set.
// - Bit 1 gates individually enabled event interrupts.
// - Bit 0 selects interrupt output or power-down input.
// - Events reach the pin only as output.
// - Both enable and output bits needed for events.
// - Event flags set regardless, cleared by status read.

// Register indices; the byte address is four times the index.
`define IDX_CTRL      8'h11
`define IDX_EVENT     8'h12
`define IDX_IRQ_STAT  8'h20
`define IDX_IRQ_MASK  8'h21

// Control register field positions.
`define B_SCR_BYPASS  11
`define B_DEPTH_HI    9
`define B_DEPTH_LO    8
`define B_FD_COL      4
`define B_POL         3
`define B_TEST        2
`define B_INT_EN      1
`define B_INT_OE      0
// Reserved control bits that must always read back as zero.
`define B_RSV_SINGLE  10
`define B_RSV_HI      7
`define B_RSV_LO      5

// Event register: flags at 13:8, enables at 5:0.
`define B_EV_STAT_LO  8
`define B_EV_EN_LO    0

// Reset values.
`define CTRL_DEPTH_RST 2'h1
`define CTRL_POL_RST   1'h1

// Decoded loopback FIFO depths in nibbles.
`define DEPTH_CODE0   4'h4
`define DEPTH_CODE1   4'h5
`define DEPTH_CODE2   4'h6
`define DEPTH_CODE3   4'h8

// Own sticky interrupt bits.
`define IRQ_B_EVENT   0
`define IRQ_B_FIFO    1
`endif

// File: include/phy_ctrl_pkg.sv
package phy_ctrl_pkg;
  // Control register fields as held in the block.
  typedef struct packed {
    logic       scr_bypass;
    logic [1:0] depth;
    logic       fd_col;
    logic       pol;
    logic       test;
    logic       int_en;
    logic       int_oe;
  } ctrl_t;

  // Register bus request as seen by the slave.
  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avs_req_t;
endpackage

// File: verif/host_side_model.sv
`default_nettype none
// Host side of the shared pin: a pull-up, plus a power-down pull low.
module host_side_model (
  input  wire logic pin_out_in,
  input  wire logic pin_oe_in,
  input  wire logic pd_req_n_in,
  output logic      pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // pin role select
  // The host pulls low only while the device does not drive the pin.
  always_comb begin
    if (pin_oe_in) begin
      pin_level_out = pin_out_in;
    end else begin
      pin_level_out = pd_req_n_in;
    end
  end
endmodule
`default_nettype wire

// File: verif/tb_phy_control_interrupt_pin_logic.sv
`default_nettype none
module tb_phy_control_interrupt_pin_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic [9:0]  addr    = 10'h000;
  logic        rd_s    = 1'b0;
  logic        wr_s    = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic        wait_s;
  logic        irq;
  logic [5:0]  ev      = 6'h00;
  logic        lb_en   = 1'b0;
  logic        rx_v    = 1'b0;
  logic [3:0]  rx_n    = 4'h0;
  logic        tx_rdy  = 1'b0;
  logic        tx_v;
  logic [3:0]  tx_n;
  logic        col_raw = 1'b0;
  logic        fdx     = 1'b0;
  logic        col;
  logic        scr;
  logic        pin_lvl;
  logic        pin_o;
  logic        pin_oe;
  logic        pd_n    = 1'b1;
  logic        pd_req;
  logic [3:0]  outq[$];
  int          err_count  = 0;
  int          num_checks = 0;

  phy_specific_control i_phy_specific_control (
    .mclk_in(clk), .reset_in(rst), .address_in(addr), .read_in(rd_s),
    .write_in(wr_s), .byteenable_in(4'hF), .writedata_in(wdata),
    .readdata_out(rdata), .waitrequest_out(wait_s), .irq_out(irq),
    .event_pulse_in(ev), .loopback_en_in(lb_en),
    .rx_nibble_valid_in(rx_v), .rx_nibble_in(rx_n),
    .tx_nibble_ready_in(tx_rdy), .tx_nibble_valid_out(tx_v),
    .tx_nibble_out(tx_n), .raw_collision_in(col_raw),
    .full_duplex_in(fdx), .collision_out(col),
    .scrambler_bypass_out(scr), .shared_irq_powerdown_pin_in(pin_lvl),
    .shared_irq_powerdown_pin_out(pin_o),
    .shared_irq_powerdown_pin_oe_out(pin_oe), .powerdown_req_out(pd_req));

  host_side_model i_host_side_model (
    .pin_out_in(pin_o), .pin_oe_in(pin_oe), .pd_req_n_in(pd_n),
    .pin_level_out(pin_lvl));

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Valid lasts one cycle, so sampling mid-cycle catches each nibble once.
  always @(negedge clk) begin
    if (tx_v === 1'b1) begin
      outq.push_back(tx_n);
    end
  end

  function automatic int depth_of(input logic [1:0] c);
    return (c == 2'h3) ? 8 : 4 + int'(c);
  endfunction

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge.
  // Values read right after the edge are those the slave showed at it.
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [15:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= {idx, 2'h0};
    wr_s  <= w;
    rd_s  <= ~w;
    wdata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_s !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      conclude();
    end
    q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdchk(input string what, input logic [7:0] idx,
                       input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 16'h0000, q);
    check(what, exp, q);
  endtask

  task automatic conclude();
    $display("Checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Bounds the run well above the expected few hundred cycles.
  initial begin
    #500000;
    err_count++;
    conclude();
  end

  // Main sequence: reset, registers, pin, events, power-down, FIFO.
  initial begin
    logic [15:0] v;
    logic [3:0]  nb;
    logic [3:0]  expq[$];
    void'($urandom(26868));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdchk("ctrl reset", 8'h11, 32'h0108);
    check("bypass reset", 32'h0, {31'h0, scr});
    repeat (8) begin
      v = 16'($urandom);
      wr(8'h11, v);
      rdchk("ctrl", 8'h11, {16'h0000, v & 16'h0B1F});
      check("bypass", {31'h0, v[11]}, {31'h0, scr});
      {col_raw, fdx} <= 2'($urandom);
      @(negedge clk);
      check("col", {31'h0, col_raw & (~fdx | v[4])}, {31'h0, col});
      @(posedge clk);
    end
    wr(8'h30, 16'hFFFF);
    rdchk("unmapped", 8'h30, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(8'h11, 16'(16'h0001 | (k << 2)));
      check("pin lvl", 32'(k[0] ^ k[1]), {31'h0, pin_lvl});
      check("pin oe", 32'h1, {31'h0, pin_oe});
    end
    wr(8'h12, 16'h0001);
    wr(8'h11, 16'h0009);
    ev <= 6'h03;
    @(posedge clk);
    ev <= 6'h00;
    @(posedge clk);
    check("gated pin", 32'h1, {31'h0, pin_lvl});
    wr(8'h11, 16'h000B);
    check("event pin", 32'h0, {31'h0, pin_lvl});
    wr(8'h11, 16'h000A);
    check("input pin", 32'h1, {31'h0, pin_lvl});
    rdchk("flags", 8'h12, 32'h0301);
    rdchk("flags clear", 8'h12, 32'h0001);
    wr(8'h11, 16'h000B);
    check("cleared pin", 32'h1, {31'h0, pin_lvl});
    wr(8'h11, 16'h0008);
    pd_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("powerdown", 32'h1, {31'h0, pd_req});
    pd_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("powerdown off", 32'h0, {31'h0, pd_req});
    wr(8'h21, 16'h0002);
    for (int c = 0; c < 4; c++) begin
      lb_en <= 1'b0;
      @(posedge clk);
      wr(8'h11, {6'h00, 2'(c), 8'h08});
      wr(8'h20, 16'h0003);
      lb_en <= 1'b1;
      outq.delete();
      expq.delete();
      repeat (10) begin
        nb = 4'($urandom);
        expq.push_back(nb);
        rx_v <= 1'b1;
        rx_n <= nb;
        @(posedge clk);
      end
      rx_v   <= 1'b0;
      tx_rdy <= 1'b1;
      repeat (10) @(posedge clk);
      tx_rdy <= 1'b0;
      repeat (2) @(posedge clk);
      check("fifo count", 32'(depth_of(2'(c))), 32'(outq.size()));
      foreach (outq[i])
        check("fifo data", {28'h0, expq[i]}, {28'h0, outq[i]});
      check("irq set", 32'h1, {31'h0, irq});
      wr(8'h20, 16'h0002);
      check("irq clear", 32'h0, {31'h0, irq});
    end
    conclude();
  end
endmodule
`default_nettype wire
